// *** bench/slst_axes.sv ***
/*
  Axis loop model: actual positions, following errors, skew limit.
  Assumes the bench calls set() from the clk domain.
*/
`timescale 1ns/1ps
module slst_axes
  import slst_pkg::*;
(
  // Clock
  input  wire logic             clk,
  // Axis quantities and limit
  output logic [AXES-1:0][15:0] act_pos,
  output logic [AXES-1:0][15:0] fol_err,
  output logic [15:0]           ext_value
);
  // Loops are level sources; values hold until reloaded
  initial begin
    act_pos   = '0;
    fol_err   = '0;
    ext_value = '0;
  end

  // Load one axis and the limit at a rising edge
  task automatic set(input int ax, input logic [15:0] p, input logic [15:0] f,
                     input logic [15:0] lim);
    @(posedge clk);
    act_pos[ax] <= p;
    fol_err[ax] <= f;
    ext_value   <= lim; // Limit loaded before the skew step
  endtask : set
endmodule : slst_axes

// *** bench/tb.sv ***
/*
  Self-checking bench for the skew and step-timer link evaluator.
  Assumes slst_pkg and the slst_axes model are compiled first.
*/
`timescale 1ns/1ps
module tb
  import slst_pkg::*;
;
  localparam int unsigned MSC = 10; // Short ms so timers move fast

  logic                  clk;
  logic                  resetn;
  logic                  eval;
  logic                  delay_enter;
  logic [AXIS_W-1:0]     delay_axis;
  slst_req_s             req;
  slst_res_s             res;
  logic [15:0]           ext_value;
  logic [AXES-1:0][15:0] act_pos;
  logic [AXES-1:0][15:0] fol_err;
  logic [AXES-1:0][15:0] step_ms;
  logic [AXES-1:0][15:0] delay_ms;
  int                    error_cnt = 0;
  int                    compares  = 0;

  slst_axes u_axes (.clk(clk), .act_pos(act_pos), .fol_err(fol_err),
                    .ext_value(ext_value));
  slst_link #(.MS_COUNT(MSC)) u_dut (.clk(clk), .resetn(resetn), .eval(eval),
    .req(req), .ext_value(ext_value), .act_pos(act_pos), .fol_err(fol_err),
    .delay_enter(delay_enter), .delay_axis(delay_axis), .res(res),
    .step_ms(step_ms), .delay_ms(delay_ms));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // One evaluation; answer is read 1 ns after the edge that samples the request
  task automatic step(input logic [7:0] t, input logic [15:0] v,
                      input logic [AXIS_W-1:0] ax, input logic p);
    @(posedge clk);
    eval <= 1'b1;
    req  <= '{link_type: t, link_value: v, axis: ax, poll: p};
    @(posedge clk);
    eval <= 1'b0;
    #1;
  endtask : step

  task automatic t_skew();
    u_axes.set(0, 16'h0000, 16'h0000, 16'h0064);
    u_axes.set(1, 16'h0096, 16'h0000, 16'h0064);
    u_axes.set(7, 16'h7000, 16'h0000, 16'h0064); // Outside the mask
    step(LT_SKEW_POS, 16'hFF03, 3'd1, 1'b0); // Upper byte must be ignored
    chk(res.skew, 16'h0096);
    chk(res.act, ACT_NEXT);
    u_axes.set(1, 16'h0064, 16'h0000, 16'h0064);
    step(LT_SKEW_POS, 16'h0003, 3'd1, 1'b0);
    chk(res.skew, 16'h0064);
    chk(res.act, ACT_WAIT);
    // Signed following errors -50 and 30 give a spread of 80
    u_axes.set(2, 16'h0000, 16'hFFCE, 16'h004F);
    u_axes.set(5, 16'h0000, 16'h001E, 16'h004F);
    step(LT_SKEW_FERR, 16'h0024, 3'd1, 1'b0);
    chk(res.skew, 16'h0050);
    chk(res.act, ACT_NEXT);
    // Full-scale spread clips at the detectable limit
    u_axes.set(0, 16'h8000, 16'h0000, 16'hFFFF);
    u_axes.set(1, 16'h7FFF, 16'h0000, 16'hFFFF);
    step(LT_SKEW_POS, 16'h0003, 3'd1, 1'b0);
    chk(res.skew, 16'h7FFF);
    chk(res.act, ACT_WAIT);
    // Two positive positions: the spread must not be taken from zero
    u_axes.set(1, 16'h7FFF, 16'h0000, 16'h0000);
    step(LT_SKEW_POS, 16'h0082, 3'd1, 1'b0);
    chk(res.skew, 16'h0FFF);
    chk(res.act, ACT_NEXT);
    // Answer stands one cycle; the spread stays readable after it
    @(posedge clk);
    #1;
    chk(res.valid, 1'b0);
    chk(res.act, ACT_NONE);
    chk(res.skew, 16'h0FFF);
    // One axis alone, then no axis: spread zero, never above a zero limit
    step(LT_SKEW_POS, 16'h0080, 3'd1, 1'b0);
    chk(res.skew, 16'h0000);
    chk(res.act, ACT_WAIT);
    step(LT_SKEW_POS, 16'hFF00, 3'd1, 1'b0); // Upper byte is no mask
    chk(res.skew, 16'h0000);
    chk(res.act, ACT_WAIT);
    $display("skew test done");
  endtask : t_skew

  task automatic t_timer();
    int n;
    step(LT_TIMER_EXP, TIMER_START, 3'd2, 1'b1);
    chk(res.act, ACT_BRANCH);
    chk(step_ms[2], 16'h0000);
    chk(step_ms[3] > 16'h0000, 1);
    step(LT_TIMER_EXP, 16'h0005, 3'd2, 1'b1);
    chk(res.act, ACT_NEXT);
    step(LT_TIMER_EXP, 16'h0005, 3'd2, 1'b0);
    chk(res.act, ACT_WAIT);
    step(LT_TIMER_NEXP, 16'h0005, 3'd2, 1'b0);
    chk(res.act, ACT_BRANCH);
    // Bounded wait for the preset to be reached
    for (n = 0; n < 200 && step_ms[2] < 16'h0005; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 200) begin
      error_cnt++;
      conclude();
    end
    step(LT_TIMER_EXP, 16'h0005, 3'd2, 1'b1);
    chk(res.act, ACT_BRANCH);
    step(LT_TIMER_EXP, 16'h0005, 3'd2, 1'b0);
    chk(res.act, ACT_BRANCH);
    step(LT_TIMER_NEXP, 16'h0005, 3'd2, 1'b1);
    chk(res.act, ACT_NEXT);
    step(LT_TIMER_NEXP, 16'h0005, 3'd2, 1'b0);
    chk(res.act, ACT_WAIT);
    chk(step_ms[2] >= 16'h0005, 1);
    step(8'h41, 16'h0000, 3'd2, 1'b0); // Not a code of this block
    chk(res.valid, 1'b1);
    chk(res.act, ACT_NONE);
    $display("timer test done");
  endtask : t_timer

  task automatic t_delay();
    @(posedge clk);
    delay_enter <= 1'b1;
    delay_axis  <= 3'd2;
    @(posedge clk);
    delay_enter <= 1'b0;
    #1;
    chk(delay_ms[2], 16'h0000);
    chk(step_ms[2] >= 16'h0005, 1);
    $display("delay test done");
  endtask : t_delay

  // Reset in mid-run: spread and timers clear, evaluation resumes at once
  task automatic t_reset();
    step(LT_SKEW_POS, 16'h0082, 3'd1, 1'b0);
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    chk(res.valid, 1'b0);
    chk(res.act, ACT_NONE);
    chk(res.skew, 16'h0000);
    chk(step_ms[2], 16'h0000);
    chk(delay_ms[3], 16'h0000);
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    step(LT_TIMER_NEXP, 16'h0005, 3'd2, 1'b1);
    chk(res.act, ACT_BRANCH);
    chk(step_ms[2], 16'h0000);
    $display("reset test done");
  endtask : t_reset

  // Main sequence: reset for 12 cycles, then the scenarios
  initial begin
    resetn      = 1'b0;
    eval        = 1'b0;
    req         = '0;
    delay_enter = 1'b0;
    delay_axis  = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_skew();
    t_timer();
    t_delay();
    t_reset();
    conclude();
  end
endmodule : tb

// *** verilog/slst_link.sv ***
/*
  Step-link evaluator for skew and step-timer links of a multi-axis
  motion sequencer, plus per-axis millisecond step and delay timers.
  Assumes the sequencer, axis loops and delay stepper share clk.
  Inputs are taken as settled on clk, so nothing is synchronised here;
  MS_COUNT sets the clk cycles per millisecond tick and must be 2 or more.
*/
`timescale 1ns/1ps
// What this block does
// - Recognise skew codes 0x3C (actual position) and 0x7F (following error).
// - Skew link value bits 0-7 are axis mask; bits 8-15 ignored.
// - Skew is largest minus smallest quantity over masked axes.
// - Detectable skew is limited to 32,767 units.
// - Following-error variant compares each axis's own following error.
// - Skew threshold comes from the extended link value.
// - Skew within threshold waits; skew above threshold advances to next step.
// - Recognise timer codes 0x54 start-or-expired and 0x74 not-expired.
// - Timer link value zero means start; 1 to 65,535 is ms preset.
// - Start-or-expired with zero restarts the running axis's step timer.
// - Polled start-or-expired: reached branches, otherwise next step.
// - Unpolled start-or-expired: wait until reached, then branch.
// - Not-expired branches while below preset; unpolled waits otherwise.
// - Exactly one step timer per axis.
// - Step timer independent of the delay-link timer.
// - Delay link restarts its own timer on entry; tests never restart.
// - Expiry may be seen up to one control loop late.
// - Non-blocking links branch when true, else go to next step.
module slst_link
  import slst_pkg::*;
#(
  parameter int unsigned MS_COUNT = slst_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Step evaluation request from the sequencer
  input  wire logic                  eval,
  input  wire slst_req_s             req,
  input  wire logic [15:0]           ext_value,
  // Axis quantities from the motion loops
  input  wire logic [AXES-1:0][15:0] act_pos,
  input  wire logic [AXES-1:0][15:0] fol_err,
  // Delay link step entry
  input  wire logic                  delay_enter,
  input  wire logic [AXIS_W-1:0]     delay_axis,
  // Decision and timer readback
  output slst_res_s                  res,
  output logic [AXES-1:0][15:0]      step_ms,
  output logic [AXES-1:0][15:0]      delay_ms
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  slst_state_s s;
  slst_state_s next_s;
  logic [15:0] skew_sat;
  logic        is_skew;
  logic        is_timer;
  logic        tmr_start;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_COUNT - 1);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One pass computes skew, timer decisions and timer updates
  always_comb begin
    logic signed [15:0] q;
    logic signed [15:0] hi;
    logic signed [15:0] lo;
    logic signed [16:0] diff;
    logic               any;
    logic [15:0]        elapsed;
    logic               reached;
    logic [MASK_W-1:0]  mask;
    q        = '0;
    hi       = '0;
    lo       = '0;
    diff     = '0;
    any      = 1'b0;
    elapsed  = s.step_ms[req.axis];
    reached  = 1'b0;
    mask     = req.link_value[MASK_LSB +: MASK_W];
    next_s   = s;

    // Millisecond prescaler; a free tick base shared by all timers
    next_s.ms_tick = (s.div == DIV_LAST);
    next_s.div     = (s.div == DIV_LAST) ? '0 : DIV_W'(s.div + 1'b1);

    // Spread over masked axes, quantity chosen by link code
    for (int i = 0; i < AXES; i++) begin
      q = (req.link_type == LT_SKEW_FERR) ? fol_err[i] : act_pos[i];
      if (mask[i]) begin
        if (!any || q > hi) hi = q;
        if (!any || q < lo) lo = q;
        any = 1'b1;
      end
    end
    diff     = {hi[15], hi} - {lo[15], lo};
    // Spread clipped so it never reports more than the limit
    skew_sat = (diff > 17'sh0_7FFF) ? SKEW_MAX : diff[15:0];

    is_skew   = (req.link_type == LT_SKEW_POS) ||
                (req.link_type == LT_SKEW_FERR);
    is_timer  = (req.link_type == LT_TIMER_EXP) ||
                (req.link_type == LT_TIMER_NEXP);
    tmr_start = eval && (req.link_type == LT_TIMER_EXP) &&
                (req.link_value == TIMER_START);

    // Expiry is judged on the loop's evaluation, hence one loop late at most
    reached = (elapsed >= req.link_value);

    // Per-axis timers: count ms, saturate, restart only on own start
    for (int i = 0; i < AXES; i++) begin
      if (tmr_start && (req.axis == AXIS_W'(i))) begin
        next_s.step_ms[i] = MS_ZERO;
      end else if (s.ms_tick && s.step_ms[i] != MS_SAT) begin
        next_s.step_ms[i] = s.step_ms[i] + 16'h0001;
      end
      // Delay timer has its own storage and its own restart
      if (delay_enter && (delay_axis == AXIS_W'(i))) begin
        next_s.delay_ms[i] = MS_ZERO;
      end else if (s.ms_tick && s.delay_ms[i] != MS_SAT) begin
        next_s.delay_ms[i] = s.delay_ms[i] + 16'h0001;
      end
    end

    // Decision, one cycle after the request
    next_s.res.valid = eval;
    next_s.res.act   = ACT_NONE;
    next_s.res.skew  = s.res.skew;
    if (eval) begin
      if (is_skew) begin
        next_s.res.skew = skew_sat;
        // Threshold is trusted as loaded beforehand; a stale limit cannot
        // be seen from here
        next_s.res.act  = (skew_sat > ext_value) ? ACT_NEXT
                                                 : ACT_WAIT;
      end else if (tmr_start) begin
        next_s.res.act = ACT_BRANCH;
      end else if (req.link_type == LT_TIMER_EXP) begin
        if (reached)       next_s.res.act = ACT_BRANCH;
        else if (req.poll) next_s.res.act = ACT_NEXT;
        else               next_s.res.act = ACT_WAIT;
      end else if (is_timer) begin
        if (!reached)      next_s.res.act = ACT_BRANCH;
        else if (req.poll) next_s.res.act = ACT_NEXT;
        else               next_s.res.act = ACT_WAIT;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // All state in one register; outputs read it directly
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s.res.valid <= 1'b0;
      s.res.act   <= ACT_NONE;
      s.res.skew  <= 16'h0000;
      s.step_ms   <= '0;
      s.delay_ms  <= '0;
      s.div       <= '0;
      s.ms_tick   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Straight from the state register
  assign res      = s.res;
  assign step_ms  = s.step_ms;
  assign delay_ms = s.delay_ms;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Checks watch the registered answer one cycle after the request; all
  // share the design clock and are off while reset is held
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_TIMER_RESTART: assert property (
    tmr_start |=> res.act == ACT_BRANCH && step_ms[$past(req.axis)] == MS_ZERO
  ) else $error("start link did not restart timer and branch");

  AST_RESULT_PULSE: assert property (
    eval |=> res.valid ##1 (res.valid == $past(eval))
  ) else $error("result valid not tied to request");

  AST_SKEW_EMPTY_WAITS: assert property (
    eval && is_skew && req.link_value[7:0] == 8'h00 |=>
      res.act == ACT_WAIT && res.skew == 16'h0000
  ) else $error("empty skew mask must report zero and wait");

  AST_SKEW_LIMIT: assert property (
    res.skew <= SKEW_MAX
  ) else $error("skew above detectable limit");

  AST_SKEW_DECIDE: assert property (
    eval && is_skew |=> (res.act == ACT_NEXT) == (res.skew > $past(ext_value))
  ) else $error("skew decision wrong against threshold");

  AST_POLL_NO_WAIT: assert property (
    eval && is_timer && req.poll |=> res.act != ACT_WAIT
  ) else $error("polled timer link must not wait");

  AST_EXP_NOPOLL: assert property (
    eval && req.link_type == LT_TIMER_EXP && !req.poll && !tmr_start |=>
      res.act != ACT_NEXT
  ) else $error("unpolled expired link fell through");

  AST_NEXP_BRANCH: assert property (
    eval && req.link_type == LT_TIMER_NEXP &&
      step_ms[req.axis] < req.link_value |=> res.act == ACT_BRANCH
  ) else $error("not-expired link did not branch");

  AST_DELAY_RESTART: assert property (
    delay_enter |=> delay_ms[$past(delay_axis)] == MS_ZERO
  ) else $error("delay entry did not restart delay timer");

  AST_TIMER_COUNT: assert property (
    s.ms_tick && !tmr_start && step_ms[0] != MS_SAT |=>
      step_ms[0] == $past(step_ms[0]) + 16'h0001
  ) else $error("step timer missed a millisecond");

  AST_UNKNOWN_NONE: assert property (
    eval && !is_skew && !is_timer |=> res.act == ACT_NONE
  ) else $error("unknown link code produced a decision");

  // Answer stands one cycle, then the port returns to idle
  AST_RESULT_IDLE: assert property (
    !eval |=> !res.valid && res.act == ACT_NONE
  ) else $error("result did not return to idle");

  AST_ACT_ONEHOT: assert property (
    $onehot(res.act)
  ) else $error("decision code not one-hot");

  // Last spread stays readable until the next skew step
  AST_SKEW_HELD: assert property (
    !(eval && is_skew) |=> res.skew == $past(res.skew)
  ) else $error("skew result changed without a skew step");

  // One axis alone has no spread
  AST_SKEW_SINGLE: assert property (
    eval && is_skew && $onehot(req.link_value[7:0]) |=> res.skew == 16'h0000
  ) else $error("single-axis skew not zero");

  // Timer decisions against the elapsed count, edge cases included
  AST_EXP_POLL_NEXT: assert property (
    eval && req.link_type == LT_TIMER_EXP && req.poll && !tmr_start &&
      step_ms[req.axis] < req.link_value |=> res.act == ACT_NEXT
  ) else $error("polled expired link did not fall through");

  AST_EXP_REACHED: assert property (
    eval && req.link_type == LT_TIMER_EXP && !tmr_start &&
      step_ms[req.axis] >= req.link_value |=> res.act == ACT_BRANCH
  ) else $error("reached preset did not branch");

  AST_NEXP_HOLD: assert property (
    eval && req.link_type == LT_TIMER_NEXP && !req.poll &&
      step_ms[req.axis] >= req.link_value |=> res.act == ACT_WAIT
  ) else $error("unpolled not-expired link did not wait");

  // Only a start link may clear a step timer; between ticks it stands still
  AST_TEST_NO_RESTART: assert property (
    eval && is_timer && !tmr_start && !s.ms_tick |=> step_ms == $past(step_ms)
  ) else $error("timer test disturbed a step timer");

  AST_DELAY_APART: assert property (
    delay_enter && !tmr_start && !s.ms_tick |=> step_ms == $past(step_ms)
  ) else $error("delay entry disturbed a step timer");

  AST_START_OWN_AXIS: assert property (
    tmr_start && req.axis != '0 && !s.ms_tick |=> step_ms[0] == $past(step_ms[0])
  ) else $error("start link touched another axis timer");

  AST_DELAY_OWN_AXIS: assert property (
    delay_enter && delay_axis != '0 && !s.ms_tick |=> delay_ms[0] == $past(delay_ms[0])
  ) else $error("delay entry touched another axis timer");

  AST_DELAY_COUNT: assert property (
    s.ms_tick && !(delay_enter && delay_axis == '0) && delay_ms[0] != MS_SAT |=>
      delay_ms[0] == $past(delay_ms[0]) + 16'h0001
  ) else $error("delay timer missed a millisecond");

  // Tick base: one pulse per period, divider never past its last count;
  // a single-cycle period would break the first check on purpose
  AST_TICK_SINGLE: assert property (
    s.ms_tick |=> !s.ms_tick
  ) else $error("millisecond tick lasted more than a cycle");

  AST_DIV_RANGE: assert property (
    s.div <= DIV_LAST
  ) else $error("tick divider ran past its last count");

endmodule : slst_link

// *** verilog/slst_pkg.sv ***
/*
  Shared constants and types for the step-link skew and timer evaluator.
  Assumes one 100 MHz clock; all neighbours run on the same clock.
*/
package slst_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned AXES     = 8;
  localparam int unsigned AXIS_W   = 3;
  localparam int unsigned MASK_LSB = 0;
  localparam int unsigned MASK_W   = 8;
  localparam int unsigned DIV_W    = 17;

  // ----------------------------------------------------------------
  // Link codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LT_SKEW_POS   = 8'h3C;
  localparam logic [7:0] LT_SKEW_FERR  = 8'h7F;
  localparam logic [7:0] LT_TIMER_EXP  = 8'h54;
  localparam logic [7:0] LT_TIMER_NEXP = 8'h74;

  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [15:0] TIMER_START = 16'h0000;
  localparam logic [15:0] MS_SAT      = 16'hFFFF;
  localparam logic [15:0] SKEW_MAX    = 16'h7FFF;
  localparam logic [15:0] MS_ZERO     = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_PERIOD_NS  = 1000000;
  localparam int unsigned MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ACT_NONE   = 4'b0001,
    ACT_BRANCH = 4'b0010,
    ACT_NEXT   = 4'b0100,
    ACT_WAIT   = 4'b1000
  } slst_act_e;

  typedef struct packed {
    logic [7:0]        link_type;
    logic [15:0]       link_value;
    logic [AXIS_W-1:0] axis;
    logic              poll;
  } slst_req_s;

  typedef struct packed {
    logic        valid;
    slst_act_e   act;
    logic [15:0] skew;
  } slst_res_s;

  typedef struct packed {
    slst_res_s              res;
    logic [AXES-1:0][15:0]  step_ms;
    logic [AXES-1:0][15:0]  delay_ms;
    logic [DIV_W-1:0]       div;
    logic                   ms_tick;
  } slst_state_s;

endpackage : slst_pkg
